// *** bench/cic_src_model.sv ***
// Interrupt source model: event pulses and port pins
module cic_src_model
    import cic_pkg::*;
(
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [4:0] fireReq,
    input wire logic [3:0] pinLevel,
    output logic [4:0] eventPulse,
    output logic [3:0] upperPortPins
);
    // ----------------------------------------
    // Sources
    // ----------------------------------------
    // Pulses last one cycle, as a real source strobes once per event
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            eventPulse <= 5'h00;
            upperPortPins <= 4'h0;
        end else begin
            eventPulse <= fireReq;
            upperPortPins <= pinLevel;
        end
    end
endmodule : cic_src_model

// *** bench/tb.sv ***
// Self-checking testbench for the interrupt control block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cic_pkg::*;
    logic ref_clk, rst_n, regWr, regRd, sleeping, rdPend;
    logic highPriorityReq, lowPriorityReq, wakeReq, branchToVector, irq;
    logic [2:0] regAddr;
    logic [7:0] regWdata, regRdata, d;
    logic [4:0] fireReq, ev;
    logic [3:0] pinLevel, pins;
    logic [15:0] note;
    logic [15:0] expQ[$];
    int mismatches = 0;
    int n_checks = 0;
    int seed = 2;
    cic_src_model srcModel (.ref_clk(ref_clk), .rst_n(rst_n), .fireReq(fireReq),
        .pinLevel(pinLevel), .eventPulse(ev), .upperPortPins(pins));
    cic_core #(.PORT_PINS(4)) uut (.ref_clk(ref_clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .timerOverflow(ev[0]), .extPin0Event(ev[1]), .extPin1Event(ev[2]),
        .extPin2Event(ev[3]), .extPin3Event(ev[4]), .upperPortPins(pins),
        .sleeping(sleeping), .highPriorityReq(highPriorityReq),
        .lowPriorityReq(lowPriorityReq), .wakeReq(wakeReq),
        .branchToVector(branchToVector), .irq(irq));
    // ----------------------------------------
    // Tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic give_verdict();
        $display("Checks %0d, mismatches %0d", n_checks, mismatches);
        if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    task automatic idle(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : idle
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        @(posedge ref_clk);
        regWr <= 1'b1;
        regAddr <= a;
        regWdata <= v;
        @(posedge ref_clk);
        regWr <= 1'b0;
    endtask : wr
    // Mask of zero marks a read whose value is not compared
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m = 8'hFF);
        @(posedge ref_clk);
        regRd <= 1'b1;
        regAddr <= a;
        expQ.push_back({m, e});
        @(posedge ref_clk);
        regRd <= 1'b0;
    endtask : rd
    task automatic fire(input logic [4:0] m);
        @(posedge ref_clk);
        fireReq <= m;
        @(posedge ref_clk);
        fireReq <= 5'h00;
        idle(3);
    endtask : fire
    // ----------------------------------------
    // Clock, monitor, watchdog
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    always @(posedge ref_clk) rdPend <= regRd;
    always @(negedge ref_clk) begin
        if (rdPend === 1'b1 && expQ.size() > 0) begin
            note = expQ.pop_front();
            check(regRdata & note[15:8], note[7:0] & note[15:8]);
        end
    end
    initial begin
        #100000;
        mismatches++;
        give_verdict();
    end
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    initial begin
        {rst_n, regWr, regRd, sleeping} = 4'h0;
        regAddr = 3'h0;
        regWdata = 8'h00;
        fireReq = 5'h00;
        pinLevel = 4'h0;
        repeat (16) @(posedge ref_clk);
        rst_n <= 1'b1;
        rd(OFF_MAIN, MAIN_RST);
        rd(OFF_EXT, EXT_RST);
        rd(OFF_CHGEN, CHGEN_RST);
        rd(OFF_RESCTL, RESCTL_RST);
        rd(OFF_STATUS, 8'h00);
        rd(OFF_MASK, MASK_RST);
        fire(5'h01);
        rd(OFF_MAIN, 8'h04);
        rd(OFF_STATUS, 8'h20);
        wr(OFF_MAIN, 8'hA4);
        idle(3);
        check({7'h00, highPriorityReq}, 8'h01);
        check({7'h00, irq}, 8'h00);
        wr(OFF_MASK, 8'h20);
        idle(3);
        check({7'h00, irq}, 8'h01);
        wr(OFF_STATUS, 8'h20);
        idle(3);
        check({7'h00, irq}, 8'h00);
        rd(OFF_STATUS, 8'h00);
        wr(OFF_MAIN, 8'h24);
        idle(3);
        check({7'h00, highPriorityReq}, 8'h00);
        wr(OFF_MAIN, 8'h20);
        rd(OFF_MAIN, 8'h20);
        fire(5'h02);
        rd(OFF_MAIN, 8'h22);
        wr(OFF_MAIN, 8'h20);
        rd(OFF_MAIN, 8'h20);
        fire(5'h1C);
        rd(OFF_EXT, 8'hC7);
        wr(OFF_EXT, 8'hF8);
        rd(OFF_EXT, 8'hF8);
        wr(OFF_EXT, 8'hC0);
        sleeping <= 1'b1;
        fire(5'h01);
        check({6'h00, wakeReq, branchToVector}, 8'h02);
        wr(OFF_MAIN, 8'hA4);
        idle(3);
        check({6'h00, wakeReq, branchToVector}, 8'h03);
        sleeping <= 1'b0;
        wr(OFF_MAIN, 8'h20);
        wr(OFF_RESCTL, 8'h80);
        rd(OFF_RESCTL, 8'h80);
        wr(OFF_EXT, 8'h08);
        fire(5'h04);
        wr(OFF_MAIN, 8'hC0);
        idle(3);
        check({6'h00, highPriorityReq, lowPriorityReq}, 8'h01);
        wr(OFF_MAIN, 8'h80);
        idle(3);
        check({6'h00, highPriorityReq, lowPriorityReq}, 8'h00);
        {pinLevel, fireReq} <= {4'h5, 5'h00};
        wr(OFF_MAIN, 8'h00);
        wr(OFF_EXT, 8'h00);
        wr(OFF_RESCTL, 8'h00);
        rd(OFF_MAIN, 8'h00);
        wr(OFF_CHGEN, 8'h0F);
        idle(3);
        rd(OFF_MAIN, 8'h01);
        wr(OFF_MAIN, 8'h00);
        rd(OFF_MAIN, 8'h01);
        rd(OFF_PORT, 8'h05);
        idle(2);
        wr(OFF_MAIN, 8'h00);
        rd(OFF_MAIN, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            wr(OFF_MASK, d);
            rd(OFF_MASK, d);
            wr(3'h7, d);
            rd(3'h7, 8'h00);
        end
        idle(3);
        give_verdict();
    end
endmodule : tb

// *** src/cic_core.sv ***
// Core interrupt control: enables, flags, priority and request to the core
// How it works
// - Flags latch regardless of interrupt enables; the change flag only for change-enabled pins
// - No priority: bit 7 gates all interrupts except irq
// - Priority: bit 7 enables high-priority interrupts
// - No priority: bit 6 is unused, bit 7 alone gates
// - Priority: bit 6 enables low-priority interrupts
// - Timer overflow: enable bit 5, flag bit 2
// - External pin zero: enable 4, flag 1
// - Upper port change sets flag bit 0
// - Persisting mismatch keeps setting the flag
// - Per-pin change enables, all off at reset
// - Bits 5..3 enable ext pins three..one
// - Priority bits act only when scheme enabled
// - Wake always; vector only if global enabled
module cic_core
    import cic_pkg::*;
#(
    parameter int PORT_PINS = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [2:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [7:0] regRdata,
    input wire logic timerOverflow,
    input wire logic extPin0Event,
    input wire logic extPin1Event,
    input wire logic extPin2Event,
    input wire logic extPin3Event,
    input wire logic [PORT_PINS-1:0] upperPortPins,
    input wire logic sleeping,
    output logic highPriorityReq,
    output logic lowPriorityReq,
    output logic wakeReq,
    output logic branchToVector,
    output logic irq
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [7:0] mainCtl_r;
    logic [7:0] extCtl_r;
    logic [PORT_PINS-1:0] chgEn_r;
    logic [7:0] resCtl_r;
    logic [7:0] evtStatus_r;
    logic [7:0] evtMask_r;
    logic [PORT_PINS-1:0] portLatch_r;
    logic [PORT_PINS-1:0] portPrev_r;
    logic mismatch;
    logic wrMain;
    logic wrExt;
    logic prioOn;
    logic pend0;
    logic pend1;
    logic pend2;
    logic pend3;
    logic pendT;
    logic pendC;
    logic hiAny;
    logic loAny;
    logic hiReq_nxt;
    logic loReq_nxt;
    logic anyEnabled;
    logic [7:0] evtSet;

    function automatic logic [7:0] clearFlags(input logic [7:0] cur, input logic [7:0] wr,
                                               input logic [7:0] fmask);
        clearFlags = (cur & fmask & wr) | (wr & ~fmask);
    endfunction : clearFlags

    assign wrMain = regWr && regAddr == OFF_MAIN;
    assign wrExt = regWr && regAddr == OFF_EXT;
    assign prioOn = resCtl_r[RESCTL_PRIORITY_SCHEME_ENABLE];
    // Mismatch against latched port value, like a reading of the port
    assign mismatch = |((upperPortPins ^ portLatch_r) & chgEn_r);

    // ------------------------------------------------------------
    // Main control register
    // ------------------------------------------------------------
    // Set wins over a software clear in the same cycle
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            mainCtl_r <= MAIN_RST;
        end else begin
            mainCtl_r <= wrMain ? clearFlags(mainCtl_r, regWdata, 8'h07) : mainCtl_r;
            if (timerOverflow) begin
                mainCtl_r[MAIN_T0IF] <= 1'b1;
            end
            if (extPin0Event) begin
                mainCtl_r[MAIN_X0IF] <= 1'b1;
            end
            if (mismatch) begin
                mainCtl_r[MAIN_CHIF] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // External control register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            extCtl_r <= EXT_RST;
        end else begin
            extCtl_r <= wrExt ? clearFlags(extCtl_r, regWdata, 8'h07) : extCtl_r;
            if (extPin3Event) begin
                extCtl_r[EXT_X3IF] <= 1'b1;
            end
            if (extPin2Event) begin
                extCtl_r[EXT_X3IF-1] <= 1'b1;
            end
            if (extPin1Event) begin
                extCtl_r[EXT_X1IF] <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // Change enables, reset control, port latch
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            chgEn_r <= CHGEN_RST[PORT_PINS-1:0];
            resCtl_r <= RESCTL_RST;
            evtMask_r <= MASK_RST;
        end else if (regWr) begin
            if (regAddr == OFF_CHGEN) begin
                chgEn_r <= regWdata[PORT_PINS-1:0];
            end
            if (regAddr == OFF_RESCTL) begin
                resCtl_r <= regWdata & 8'h80;
            end
            if (regAddr == OFF_MASK) begin
                evtMask_r <= regWdata;
            end
        end
    end

    // A read of the port snapshots the pins and ends the mismatch
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            portLatch_r <= '0;
            portPrev_r <= '0;
        end else begin
            portPrev_r <= upperPortPins;
            if (regRd && regAddr == OFF_PORT) begin
                portLatch_r <= upperPortPins;
            end
        end
    end

    // ------------------------------------------------------------
    // Request generation
    // ------------------------------------------------------------
    assign pendT = mainCtl_r[MAIN_T0IF] & mainCtl_r[MAIN_T0IE];
    assign pend0 = mainCtl_r[MAIN_X0IF] & mainCtl_r[MAIN_X0IE];
    assign pendC = mainCtl_r[MAIN_CHIF] & mainCtl_r[MAIN_CHIE];
    assign pend3 = extCtl_r[EXT_X3IF] & extCtl_r[EXT_X3IE];
    assign pend2 = extCtl_r[EXT_X3IF-1] & extCtl_r[EXT_X3IE-1];
    assign pend1 = extCtl_r[EXT_X1IF] & extCtl_r[EXT_X1IE];
    assign anyEnabled = pendT | pend0 | pendC | pend1 | pend2 | pend3;

    // Core sources high priority; ext pins one/two by their bits, three fixed high
    always_comb begin
        hiAny = pendT | pend0 | pendC | pend3 |
                (pend2 & extCtl_r[EXT_X2IP]) | (pend1 & extCtl_r[EXT_X1IP]);
        loAny = (pend2 & ~extCtl_r[EXT_X2IP]) | (pend1 & ~extCtl_r[EXT_X1IP]);
        if (prioOn) begin
            hiReq_nxt = mainCtl_r[MAIN_GIE] & hiAny;
            loReq_nxt = mainCtl_r[MAIN_GIE] & mainCtl_r[MAIN_PEIE] & loAny;
        end else begin
            // Without priority every source is treated as unmasked core source
            hiReq_nxt = mainCtl_r[MAIN_GIE] & anyEnabled;
            loReq_nxt = 1'b0;
        end
    end

    assign evtSet = {2'b00, timerOverflow, extPin0Event, |(upperPortPins ^ portPrev_r),
                     extPin1Event, extPin2Event, extPin3Event};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            highPriorityReq <= 1'b0;
            lowPriorityReq <= 1'b0;
            wakeReq <= 1'b0;
            branchToVector <= 1'b0;
        end else begin
            highPriorityReq <= hiReq_nxt;
            lowPriorityReq <= loReq_nxt;
            wakeReq <= sleeping & anyEnabled;
            branchToVector <= sleeping & anyEnabled & mainCtl_r[MAIN_GIE];
        end
    end

    // ------------------------------------------------------------
    // Event status, mask and level interrupt
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            evtStatus_r <= 8'h00;
        end else if (regWr && regAddr == OFF_STATUS) begin
            evtStatus_r <= (evtStatus_r & ~regWdata) | evtSet;
        end else begin
            evtStatus_r <= evtStatus_r | evtSet;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= |(evtStatus_r & evtMask_r);
        end
    end

    // ------------------------------------------------------------
    // Read port
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata <= 8'h00;
        end else if (regRd) begin
            unique case (regAddr)
                OFF_MAIN: regRdata <= mainCtl_r;
                OFF_EXT: regRdata <= extCtl_r;
                OFF_CHGEN: regRdata <= 8'(chgEn_r);
                OFF_RESCTL: regRdata <= resCtl_r;
                OFF_STATUS: regRdata <= evtStatus_r;
                OFF_MASK: regRdata <= evtMask_r;
                OFF_PORT: regRdata <= 8'(upperPortPins);
                default: regRdata <= 8'h00;
            endcase
        end else begin
            regRdata <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_timer_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        timerOverflow |=> mainCtl_r[MAIN_T0IF])
        else $error("timer flag not set");
    a_pin0_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        extPin0Event |=> mainCtl_r[MAIN_X0IF])
        else $error("pin0 flag not set");
    a_flag_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mainCtl_r[MAIN_T0IF] && !wrMain |=> mainCtl_r[MAIN_T0IF])
        else $error("timer flag dropped");
    a_change_flag_set: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mismatch |=> mainCtl_r[MAIN_CHIF])
        else $error("change flag not set");
    a_global_block: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !mainCtl_r[MAIN_GIE] |=> !highPriorityReq && !lowPriorityReq)
        else $error("request while disabled");
    a_high_request: assert property (@(posedge ref_clk) disable iff (!rst_n)
        prioOn && mainCtl_r[MAIN_GIE] && pendT |=> highPriorityReq)
        else $error("high request missing");
    a_low_gate: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !mainCtl_r[MAIN_PEIE] |=> !lowPriorityReq)
        else $error("low request without enable");
    a_ext3_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        extPin3Event |=> extCtl_r[EXT_X3IF])
        else $error("ext3 flag not set");
    a_wake_branch: assert property (@(posedge ref_clk) disable iff (!rst_n)
        branchToVector |-> wakeReq)
        else $error("branch without wake");
    a_branch_gie: assert property (@(posedge ref_clk) disable iff (!rst_n)
        branchToVector |-> $past(mainCtl_r[MAIN_GIE]))
        else $error("branch without global enable");
    a_wake_sleep: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wakeReq |-> $past(sleeping))
        else $error("wake while running");
    a_ext1_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        extPin1Event |=> extCtl_r[EXT_X1IF])
        else $error("ext1 flag not set");
    a_ext2_flag: assert property (@(posedge ref_clk) disable iff (!rst_n)
        extPin2Event |=> extCtl_r[EXT_X3IF-1])
        else $error("ext2 flag not set");
    a_ext_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        extCtl_r[EXT_X3IF] && !wrExt |=> extCtl_r[EXT_X3IF])
        else $error("ext3 flag dropped");
    a_pin0_sticky: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mainCtl_r[MAIN_X0IF] && !wrMain |=> mainCtl_r[MAIN_X0IF])
        else $error("pin0 flag dropped");
    a_change_gated: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !(|chgEn_r) && !mainCtl_r[MAIN_CHIF] |=> !mainCtl_r[MAIN_CHIF])
        else $error("change flag without enabled pin");
    a_chgen_write: assert property (@(posedge ref_clk) disable iff (!rst_n)
        regWr && regAddr == OFF_CHGEN |=> chgEn_r == $past(regWdata[PORT_PINS-1:0]))
        else $error("change enables not written");
    a_mismatch_holds: assert property (@(posedge ref_clk) disable iff (!rst_n)
        mismatch && wrMain |=> mainCtl_r[MAIN_CHIF])
        else $error("clear beat persisting mismatch");
    a_ext_enables: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrExt |=> extCtl_r[5:3] == $past(regWdata[5:3]))
        else $error("ext enables not written");
    a_prio_bits: assert property (@(posedge ref_clk) disable iff (!rst_n)
        wrExt |=> extCtl_r[7:6] == $past(regWdata[7:6]))
        else $error("priority bits not written");
    a_resctl_only7: assert property (@(posedge ref_clk) disable iff (!rst_n)
        resCtl_r[6:0] == 7'h00)
        else $error("reserved reset control bits set");
    a_prio_ignored: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !prioOn |=> !lowPriorityReq)
        else $error("low request with scheme off");
    a_flat_request: assert property (@(posedge ref_clk) disable iff (!rst_n)
        !prioOn && mainCtl_r[MAIN_GIE] && anyEnabled |=> highPriorityReq)
        else $error("request missing with scheme off");
    a_low_request: assert property (@(posedge ref_clk) disable iff (!rst_n)
        prioOn && mainCtl_r[MAIN_GIE] && mainCtl_r[MAIN_PEIE] && loAny |=> lowPriorityReq)
        else $error("low request missing");
    a_high_ext2: assert property (@(posedge ref_clk) disable iff (!rst_n)
        prioOn && mainCtl_r[MAIN_GIE] && pend2 && extCtl_r[EXT_X2IP] |=> highPriorityReq)
        else $error("ext2 high request missing");
    // ------------------------------------------------------------
    // Coverage of main scenarios
    // ------------------------------------------------------------
    c_high_req: cover property (@(posedge ref_clk) disable iff (!rst_n) highPriorityReq);
    c_low_req: cover property (@(posedge ref_clk) disable iff (!rst_n) lowPriorityReq);
    c_wake: cover property (@(posedge ref_clk) disable iff (!rst_n) wakeReq && !branchToVector);
    c_branch: cover property (@(posedge ref_clk) disable iff (!rst_n) branchToVector);
    // Persisting mismatch is the case software most often gets wrong
    c_mismatch_clear: cover property (@(posedge ref_clk) disable iff (!rst_n) mismatch && wrMain);
endmodule : cic_core

// *** src/cic_pkg.sv ***
// Package of offsets, field positions and reset values for the interrupt control block
package cic_pkg;
    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [2:0] OFF_MAIN = 3'h0;
    localparam logic [2:0] OFF_EXT = 3'h1;
    localparam logic [2:0] OFF_CHGEN = 3'h2;
    localparam logic [2:0] OFF_RESCTL = 3'h3;
    localparam logic [2:0] OFF_STATUS = 3'h4;
    localparam logic [2:0] OFF_MASK = 3'h5;
    localparam logic [2:0] OFF_PORT = 3'h6;
    // ------------------------------------------------------------
    // Main control fields
    // ------------------------------------------------------------
    localparam int MAIN_GIE = 7;
    localparam int MAIN_PEIE = 6;
    localparam int MAIN_T0IE = 5;
    localparam int MAIN_X0IE = 4;
    localparam int MAIN_CHIE = 3;
    localparam int MAIN_T0IF = 2;
    localparam int MAIN_X0IF = 1;
    localparam int MAIN_CHIF = 0;
    // ------------------------------------------------------------
    // External control and reset control fields
    // ------------------------------------------------------------
    localparam int EXT_X2IP = 7;
    localparam int EXT_X1IP = 6;
    localparam int EXT_X3IE = 5;
    localparam int EXT_X1IE = 3;
    localparam int EXT_X3IF = 2;
    localparam int EXT_X1IF = 0;
    localparam int RESCTL_PRIORITY_SCHEME_ENABLE = 7;
    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0] MAIN_RST = 8'h00;
    localparam logic [7:0] EXT_RST = 8'hC0;
    localparam logic [7:0] CHGEN_RST = 8'h00;
    localparam logic [7:0] RESCTL_RST = 8'h00;
    localparam logic [7:0] MASK_RST = 8'h00;
endpackage : cic_pkg
